// >>> verilog/alert_map.svh
// Purpose: register offsets, field positions, reset values and timing for the alert block
// Assumes: 8-bit registers reached at their printed offsets
// Notes:   definitions only
`ifndef ALERT_MAP_SVH
`define ALERT_MAP_SVH

// ==========================================================
// register offsets
`define CFG4_ADDR       8'h04
`define RATE_ADDR       8'h05
`define FQ_ADDR         8'h06
`define MASK1_ADDR      8'h08
`define MASK2_ADDR      8'h09
`define MASK3_ADDR      8'h0A
`define STAT1_ADDR      8'h4F
`define STAT2_ADDR      8'h50
`define STAT3_ADDR      8'h51

// ==========================================================
// field positions
`define B_LH            7
`define B_LL            6
`define B_RH            5
`define B_RL            4
`define B_RD            3
`define B_TPCT          4
`define B_TA            3
`define B_TS            2
`define B_FS            7
`define B_FA            6
`define B_REF           7
`define B_ALERT         0
`define B_FQ4           3
`define B_FQ3           2
`define B_FQ2           1

// ==========================================================
// defined-bit masks, reserved bits read zero
`define M1_DEF          8'hF8
`define M1_LOCAL        8'hC0
`define M1_REMOTE       8'h38
`define M2_DEF          8'h1C
`define M2_COMP         8'h18
`define M3_DEF          8'hC0

// ==========================================================
// reset values
`define RATE_RST        8'h07
`define FQ_RST          8'h01
`define MASK_RST        8'h00
`define CFG4_RST        8'h00

// ==========================================================
// rate codes and queue lengths
`define RATE_MAX        8'h0A
`define RATE_NOAVG_MIN  8'h08
`define FQ_LEN_1        3'h1
`define FQ_LEN_2        3'h2
`define FQ_LEN_3        3'h3
`define FQ_LEN_4        3'h4

// ==========================================================
// timing: 64 conversions per second is the fastest period
`define CLK_PERIOD_NS   8
`define FASTEST_PER_US  15625
`define NS_PER_US       1000

`endif

// >>> verilog/alert_pkg.sv
// Purpose: shared types of the alert block
// Assumes: nothing beyond the map header
// Notes:   types only
package alert_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] qlen_t;
endpackage

// >>> verilog/pin_sync.sv
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: output changes only once stages two and three agree
// Notes:   first stage feeds the second stage only
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // pin and filtered level
    input  wire logic din,
    output logic      dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic dout_nxt;

    // ==========================================================
    // accept a change only when the last two stages agree
    always_comb begin
        dout_nxt = (s2_r == s3_r) ? s3_r : dout;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end
endmodule

// >>> verilog/fault_queue.sv
// Purpose: consecutive out-of-limit counter for one temperature channel
// Assumes: sample is a one-cycle pulse per finished measurement
// Notes:   full is sticky until q_clear
`timescale 1ns/100ps
`include "alert_map.svh"
module fault_queue (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    // control
    input  wire logic          q_clear,
    input  wire logic          sample,
    input  wire logic          fault,
    input  wire alert_pkg::qlen_t q_len,
    // state
    output logic               full
);
    import alert_pkg::*;

    qlen_t cnt_r;
    qlen_t cnt_nxt;
    qlen_t cnt_base;
    qlen_t cnt_inc;
    logic  full_nxt;

    // ==========================================================
    // a sample in the clearing cycle still counts, so no result is lost
    always_comb begin
        cnt_base = q_clear ? '0 : cnt_r;
        cnt_inc  = (cnt_base >= `FQ_LEN_4) ? `FQ_LEN_4 : qlen_t'(cnt_base + `FQ_LEN_1);
        cnt_nxt  = cnt_base;
        full_nxt = q_clear ? 1'b0 : full;
        if (sample) begin
            cnt_nxt = fault ? cnt_inc : '0;
            if (fault && cnt_inc >= q_len) begin
                full_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            full  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            full  <= full_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    queue_fill_a: assert property ($rose(full) |-> $past(sample && fault))
        else $error("fault queue filled without a faulting sample");
    queue_clear_a: assert property ((q_clear && !sample) |=> (!full && cnt_r == '0))
        else $error("fault queue not cleared");
endmodule

// >>> verilog/limit_alert_fault_queue.sv
// Purpose: status, mask and alert logic with temperature fault queue and rate select
// Assumes: register port driven by the serial bus engine; comparisons made upstream
// Notes:   alert outputs are open-drain, pin pulled low while its enable is high
// Functional notes
// - Two alert outputs: latched bus alert and self-clearing comparator alert.
// - Bus alert held until condition gone and status read or response cycle.
// - Out-of-limit sets status bit; unmasked source also pulls bus alert low.
// - Comparator alert low while any unmasked source is out of limits.
// - Mask blocks only the alert; the status bit still sets.
// - Mask one: bits 7..3 local high/low, remote high/low, diode error.
// - Mask two: bit 4 timer limit, bit 3 output asserted, bit 2 pin.
// - Pin-transition mask affects only the bus alert, not the comparator.
// - Mask three: bit 7 fan stall, bit 6 alarm speed.
// - Stall pin drives stall by default; config four bit 7 makes it reference.
// - Fault queue filters only temperature channels, bus alert only.
// - Separate counter per channel; fill after programmed consecutive faults.
// - Queue counters ignore the status bits.
// - Queue length decode: 000x=1, 001x=2, 01xx=3, 1xxx=4.
// - Queues cleared by response cycle, status one read, or reset.
// - Queue reset releases bus alert; it returns when the queue refills.
// - Rate codes 0x00..0x0A, 0.0625 to 64 per second, doubling.
// - No averaging at 16, 32 and 64 conversions per second.
// - New rate takes effect only after the running loop ends.
// - High limit flags at greater-or-equal, low limit at strictly less.
// - Status three bit 0 reads one while the bus alert is held low.
// - Status bits sticky; cleared by a read after the condition is gone.
`timescale 1ns/100ps
`include "alert_map.svh"
module limit_alert_fault_queue #(
    parameter int BASE_CYCLES = `FASTEST_PER_US * `NS_PER_US / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr_en,
    input  wire alert_pkg::reg8_t reg_wdata,
    input  wire logic             reg_rd_en,
    output alert_pkg::reg8_t      reg_rdata,
    input  wire logic             ara_done,
    // temperature results, valid with their done pulse
    input  wire logic             local_done,
    input  wire logic             local_high_flag,
    input  wire logic             local_low_flag,
    input  wire logic             remote_done,
    input  wire logic             remote_high_flag,
    input  wire logic             remote_low_flag,
    input  wire logic             remote_diode_err,
    // other sources, levels
    input  wire logic             overtemp_timer_exceeded,
    input  wire logic             overtemp_output_asserted,
    input  wire logic             overtemp_io_pin_i,
    input  wire logic             fan_stall_flag,
    input  wire logic             fan_alarm_speed_flag,
    input  wire logic             loop_end,
    // alert pins
    output logic                  latched_bus_alert_out_n,
    output logic                  latched_bus_alert_out_oe,
    output logic                  comp_alert_n,
    output logic                  comp_alert_oe,
    // stall pin and status
    output logic                  fan_fault_o,
    output logic                  fan_fault_oe,
    output logic                  ref_mode,
    output logic                  overtemp_pin_active,
    // conversion control
    output logic                  conv_start,
    output alert_pkg::reg8_t      active_rate,
    output logic                  averaging_en
);
    import alert_pkg::*;

    // ==========================================================
    // state
    reg8_t       rate_r, rate_nxt;
    reg8_t       rate_act_r, rate_act_nxt;
    reg8_t       fq_r, fq_nxt;
    reg8_t       mask1_r, mask1_nxt;
    reg8_t       mask2_r, mask2_nxt;
    reg8_t       mask3_r, mask3_nxt;
    reg8_t       cfg4_r, cfg4_nxt;
    reg8_t       cur1_r, cur1_nxt;
    reg8_t       st1_r, st1_nxt;
    reg8_t       st2_r, st2_nxt;
    reg8_t       st3_r, st3_nxt;
    reg8_t       rdata_r, rdata_nxt;
    logic        bus_n_r, bus_n_nxt;
    logic        comp_n_r, comp_n_nxt;
    logic        stall_r, stall_nxt;
    logic        conv_r, conv_nxt;
    logic [31:0] cnt_r, cnt_nxt;

    // ==========================================================
    // combinational helpers
    logic        pin_lvl;
    logic        ts_cond;
    logic        clr1, clr2, clr3;
    logic        q_clear;
    logic        l_full, r_full;
    logic        l_fault, r_fault;
    logic        bus_req, comp_req;
    logic        mask_wr;
    reg8_t       cond2, cond3;
    reg8_t       rate_gap;
    logic [31:0] period;
    qlen_t       q_len;

    // queue length by priority decode of the low nibble
    function automatic qlen_t q_len_f(input reg8_t v);
        if (v[`B_FQ4]) begin
            return `FQ_LEN_4;
        end else if (v[`B_FQ3]) begin
            return `FQ_LEN_3;
        end else if (v[`B_FQ2]) begin
            return `FQ_LEN_2;
        end
        return `FQ_LEN_1;
    endfunction

    // ==========================================================
    // pin synchroniser; the pin is active low
    pin_sync #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .din      (overtemp_io_pin_i),
        .dout     (pin_lvl)
    );

    assign ts_cond = ~pin_lvl;

    // comparisons arrive flagged upstream with >= for high and < for low
    assign l_fault = local_high_flag | local_low_flag;
    assign r_fault = remote_high_flag | remote_low_flag | remote_diode_err;
    assign q_clear = clr1;
    assign q_len   = q_len_f(fq_r);

    // one counter per channel, fed by raw results, not by status bits
    fault_queue u_fq_local (
        .core_clk (core_clk),
        .rst      (rst),
        .q_clear  (q_clear),
        .sample   (local_done),
        .fault    (l_fault),
        .q_len    (q_len),
        .full     (l_full)
    );

    fault_queue u_fq_remote (
        .core_clk (core_clk),
        .rst      (rst),
        .q_clear  (q_clear),
        .sample   (remote_done),
        .fault    (r_fault),
        .q_len    (q_len),
        .full     (r_full)
    );

    // ==========================================================
    // next-state logic for registers, status and alerts
    always_comb begin
        rate_nxt     = rate_r;
        fq_nxt       = fq_r;
        mask1_nxt    = mask1_r;
        mask2_nxt    = mask2_r;
        mask3_nxt    = mask3_r;
        cfg4_nxt     = cfg4_r;
        rate_act_nxt = rate_act_r;
        rdata_nxt    = rdata_r;
        cur1_nxt     = cur1_r;
        mask_wr      = 1'b0;
        // register writes; reserved mask bits are dropped
        if (reg_wr_en) begin
            case (reg_addr)
                `CFG4_ADDR:  cfg4_nxt  = reg_wdata;
                `RATE_ADDR:  rate_nxt  = reg_wdata;
                `FQ_ADDR:    fq_nxt    = reg_wdata;
                `MASK1_ADDR: mask1_nxt = reg_wdata & `M1_DEF;
                `MASK2_ADDR: mask2_nxt = reg_wdata & `M2_DEF;
                `MASK3_ADDR: mask3_nxt = reg_wdata & `M3_DEF;
                default: ;
            endcase
            mask_wr = (reg_addr == `MASK1_ADDR) || (reg_addr == `MASK2_ADDR)
                   || (reg_addr == `MASK3_ADDR);
        end
        // read clears, each tied to its own status register
        clr1 = ara_done || (reg_rd_en && reg_addr == `STAT1_ADDR);
        clr2 = ara_done || (reg_rd_en && reg_addr == `STAT2_ADDR);
        clr3 = ara_done || (reg_rd_en && reg_addr == `STAT3_ADDR);
        // a reserved code is kept for readback but never applied
        if (loop_end && rate_r <= `RATE_MAX) begin
            rate_act_nxt = rate_r;
        end
        // latest temperature condition per channel
        if (local_done) begin
            cur1_nxt[`B_LH] = local_high_flag;
            cur1_nxt[`B_LL] = local_low_flag;
        end
        if (remote_done) begin
            cur1_nxt[`B_RH] = remote_high_flag;
            cur1_nxt[`B_RL] = remote_low_flag;
            cur1_nxt[`B_RD] = remote_diode_err;
        end
        cond2          = '0;
        cond2[`B_TPCT] = overtemp_timer_exceeded;
        cond2[`B_TA]   = overtemp_output_asserted;
        cond2[`B_TS]   = ts_cond;
        cond3          = '0;
        cond3[`B_FS]   = fan_stall_flag;
        cond3[`B_FA]   = fan_alarm_speed_flag;
        // sticky status, mask-independent; a live condition beats the clear
        st1_nxt = (cur1_r & `M1_DEF) | (st1_r & ~{8{clr1}});
        st2_nxt = cond2 | (st2_r & ~{8{clr2}});
        st3_nxt = cond3 | (st3_r & ~{8{clr3}});
        // bus alert: temperature through the queues, the rest through status
        bus_req = (l_full && |(st1_r & ~mask1_r & `M1_LOCAL))
               || (r_full && |(st1_r & ~mask1_r & `M1_REMOTE))
               || |(st2_r & ~mask2_r & `M2_DEF)
               || |(st3_r & ~mask3_r & `M3_DEF);
        // comparator alert: live levels, pin transition ignores its mask
        comp_req = |(cur1_r & ~mask1_r & `M1_DEF)
                || |(cond2 & ~mask2_r & `M2_COMP)
                || ts_cond
                || |(cond3 & ~mask3_r & `M3_DEF);
        bus_n_nxt  = ~bus_req;
        comp_n_nxt = ~comp_req;
        stall_nxt  = fan_stall_flag && !cfg4_r[`B_REF];
        // register reads, unmapped offsets answer zero
        if (reg_rd_en) begin
            case (reg_addr)
                `CFG4_ADDR:  rdata_nxt = cfg4_r;
                `RATE_ADDR:  rdata_nxt = rate_r;
                `FQ_ADDR:    rdata_nxt = fq_r;
                `MASK1_ADDR: rdata_nxt = mask1_r;
                `MASK2_ADDR: rdata_nxt = mask2_r;
                `MASK3_ADDR: rdata_nxt = mask3_r;
                `STAT1_ADDR: rdata_nxt = st1_r;
                `STAT2_ADDR: rdata_nxt = st2_r;
                `STAT3_ADDR: rdata_nxt = st3_r | {7'h00, ~bus_n_r};
                default:     rdata_nxt = '0;
            endcase
        end
        // conversion tick; slower codes double the fastest period
        rate_gap = `RATE_MAX - rate_act_r;
        period   = 32'(BASE_CYCLES) << rate_gap[3:0];
        conv_nxt = (cnt_r == '0);
        cnt_nxt  = conv_nxt ? period - 32'h0000_0001 : cnt_r - 32'h0000_0001;
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rate_r     <= `RATE_RST;
            rate_act_r <= `RATE_RST;
            fq_r       <= `FQ_RST;
            mask1_r    <= `MASK_RST;
            mask2_r    <= `MASK_RST;
            mask3_r    <= `MASK_RST;
            cfg4_r     <= `CFG4_RST;
            cur1_r     <= '0;
            st1_r      <= '0;
            st2_r      <= '0;
            st3_r      <= '0;
            rdata_r    <= '0;
            bus_n_r    <= 1'b1;
            comp_n_r   <= 1'b1;
            stall_r    <= 1'b0;
            conv_r     <= 1'b0;
            cnt_r      <= '0;
        end else begin
            rate_r     <= rate_nxt;
            rate_act_r <= rate_act_nxt;
            fq_r       <= fq_nxt;
            mask1_r    <= mask1_nxt;
            mask2_r    <= mask2_nxt;
            mask3_r    <= mask3_nxt;
            cfg4_r     <= cfg4_nxt;
            cur1_r     <= cur1_nxt;
            st1_r      <= st1_nxt;
            st2_r      <= st2_nxt;
            st3_r      <= st3_nxt;
            rdata_r    <= rdata_nxt;
            bus_n_r    <= bus_n_nxt;
            comp_n_r   <= comp_n_nxt;
            stall_r    <= stall_nxt;
            conv_r     <= conv_nxt;
            cnt_r      <= cnt_nxt;
        end
    end

    // ==========================================================
    // outputs; open-drain pins drive low only while enabled
    assign reg_rdata                = rdata_r;
    assign latched_bus_alert_out_n  = bus_n_r;
    assign latched_bus_alert_out_oe = ~bus_n_r;
    assign comp_alert_n             = comp_n_r;
    assign comp_alert_oe            = ~comp_n_r;
    assign fan_fault_o              = 1'b0;
    assign fan_fault_oe             = stall_r;
    assign ref_mode                 = cfg4_r[`B_REF];
    assign overtemp_pin_active      = st2_r[`B_TS];
    assign conv_start               = conv_r;
    assign active_rate              = rate_act_r;
    assign averaging_en             = (rate_act_r < `RATE_NOAVG_MIN);

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    bus_alert_hold_a: assert property (
        (!bus_n_r && !clr1 && !clr2 && !clr3 && !$past(clr1) && !$past(clr2)
         && !$past(clr3) && !mask_wr && !$past(mask_wr)) |=> !bus_n_r)
        else $error("bus alert released without service");
    status_sticky_a: assert property (
        !clr1 |=> ((st1_r & $past(st1_r)) == $past(st1_r)))
        else $error("status bit dropped without a read");
    status_set_a: assert property (
        1'b1 |=> ((st1_r & $past(cur1_r)) == ($past(cur1_r) & `M1_DEF)))
        else $error("status bit not set by out-of-limit result");
    comp_clear_a: assert property (
        (!comp_req)[*2] |-> comp_n_r)
        else $error("comparator alert did not release");
    pin_comp_a: assert property (ts_cond |=> !comp_n_r)
        else $error("pin activity failed to pull comparator alert");
    rate_hold_a: assert property (!$past(loop_end) |-> $stable(rate_act_r))
        else $error("rate changed outside loop end");
    noavg_a: assert property (
        (rate_act_r >= `RATE_NOAVG_MIN) |-> !averaging_en)
        else $error("averaging left on at a fast rate");
    queue_release_a: assert property (
        (clr1 && !local_done && !remote_done) |=> (!l_full && !r_full))
        else $error("queue not released by reset");
    alert_flag_a: assert property (
        (reg_rd_en && reg_addr == `STAT3_ADDR) |=> (rdata_r[`B_ALERT] == !$past(bus_n_r)))
        else $error("alert status bit wrong");
    stall_pin_a: assert property (
        (cfg4_r[`B_REF] && $past(cfg4_r[`B_REF])) |-> !fan_fault_oe)
        else $error("stall pin driven in reference mode");
endmodule

// >>> verilog/unused_placeholder.sv
// Purpose: none
// Assumes: none
// Notes:   empty compilation unit
`timescale 1ns/100ps

// >>> verification/host_model.sv
// Purpose: host-side register master for the alert block
// Assumes: strobes launched at the falling edge, one cycle each
// Notes:   released address and data lines show the inverse of their last value; strobes return to zero
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic             core_clk,
    // register port
    output logic [7:0]            reg_addr,
    output logic                  reg_wr_en,
    output alert_pkg::reg8_t      reg_wdata,
    output logic                  reg_rd_en,
    output logic                  ara_done,
    input  wire alert_pkg::reg8_t reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr_en, reg_rd_en, ara_done} = '0;
    // one access; read data taken two falling edges after the strobe edge
    task automatic acc(input logic [7:0] a, d, input logic w, r, p, output logic [7:0] q);
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr_en, reg_rd_en, ara_done} = {a, d, w, r, p};
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr_en, reg_rd_en, ara_done} = {~a, ~d, 3'h0};
        @(negedge core_clk);
        q = reg_rdata;
    endtask
endmodule

// >>> verification/limit_alert_fault_queue_test.sv
// Purpose: self-checking bench for the alert block
// Assumes: small base period so rate changes are quick
// Notes:   inputs change at the falling edge only
`timescale 1ns/100ps
module limit_alert_fault_queue_test;
    import alert_pkg::*;
    logic [7:0] reg_addr;
    reg8_t reg_wdata, reg_rdata, active_rate, q;
    logic core_clk = 0, rst = 1, reg_wr_en, reg_rd_en, ara_done, loop_end = 0;
    logic local_done = 0, local_high_flag = 0, local_low_flag = 0, remote_done = 0;
    logic remote_high_flag = 0, remote_low_flag = 0, remote_diode_err = 0;
    logic overtemp_timer_exceeded = 0, overtemp_output_asserted = 0, overtemp_io_pin_i = 1;
    logic fan_stall_flag = 0, fan_alarm_speed_flag = 0;
    logic latched_bus_alert_out_n, comp_alert_n, fan_fault_oe, ref_mode, averaging_en;
    logic latched_bus_alert_out_oe, comp_alert_oe, fan_fault_o, overtemp_pin_active, conv_start;
    int num_errors = 0, num_checks = 0;
    always #4 core_clk = ~core_clk;
    host_model host_model_inst (.core_clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .ara_done, .reg_rdata);
    limit_alert_fault_queue #(.BASE_CYCLES(4)) limit_alert_fault_queue_inst (.core_clk, .rst,
        .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .ara_done, .local_done,
        .local_high_flag, .local_low_flag, .remote_done, .remote_high_flag, .remote_low_flag,
        .remote_diode_err, .overtemp_timer_exceeded, .overtemp_output_asserted,
        .overtemp_io_pin_i, .fan_stall_flag, .fan_alarm_speed_flag, .loop_end,
        .latched_bus_alert_out_n, .latched_bus_alert_out_oe, .comp_alert_n,
        .comp_alert_oe, .fan_fault_o, .fan_fault_oe, .ref_mode, .overtemp_pin_active,
        .conv_start, .active_rate, .averaging_en);
    task automatic check(input string what, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        host_model_inst.acc(a, d, 1'b1, 1'b0, 1'b0, q);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        host_model_inst.acc(a, 8'h00, 1'b0, 1'b1, 1'b0, q);
        check($sformatf("reg %h", a), q, exp);
    endtask
    // one result on both channels, then time for status and alerts to land
    task automatic meas(input logic lh, rl);
        @(negedge core_clk);
        {local_done, remote_done, local_high_flag, remote_low_flag} = {2'b11, lh, rl};
        @(negedge core_clk);
        {local_done, remote_done} = 2'b00;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic alerts(input logic bus, comp);
        check("bus alert", latched_bus_alert_out_n, bus);
        check("comp alert", comp_alert_n, comp);
        check("bus oe", latched_bus_alert_out_oe, !bus);
        check("comp oe", comp_alert_oe, !comp);
    endtask
    // reset values and reserved mask bits
    task automatic t_regs();
        logic [7:0] a[3] = '{8'h08, 8'h09, 8'h0A};
        logic [7:0] m[3] = '{8'hF8, 8'h1C, 8'hC0};
        alerts(1, 1);
        rd(8'h05, 8'h07);
        rd(8'h06, 8'h01);
        for (int i = 0; i < 3; i++) begin
            rd(a[i], 8'h00);
            wr(a[i], 8'hFF);
            rd(a[i], m[i]);
            wr(a[i], 8'h00);
        end
    endtask
    // sticky status, queue clear by status read releases the bus alert
    task automatic t_alert();
        meas(1, 0);
        alerts(0, 0);
        rd(8'h4F, 8'h80);
        repeat (2) @(negedge core_clk);
        alerts(1, 0);
        meas(0, 0);
        alerts(1, 1);
        rd(8'h4F, 8'h80);
        rd(8'h4F, 8'h00);
        rd(8'h51, 8'h00);
    endtask
    // length two, separate counters per channel, cleared by a response cycle
    task automatic t_queue();
        wr(8'h06, 8'h03);
        meas(1, 0);
        alerts(1, 0);
        meas(0, 1);
        alerts(1, 0);
        meas(1, 1);
        alerts(0, 0);
        host_model_inst.acc(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, q);
        repeat (2) @(negedge core_clk);
        alerts(1, 0);
        meas(0, 0);
        host_model_inst.acc(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, q);
        rd(8'h4F, 8'h00);
        wr(8'h06, 8'h06);
        repeat (2) meas(1, 0);
        alerts(1, 0);
        meas(1, 0);
        alerts(0, 0);
        meas(0, 0);
        rd(8'h4F, 8'h80);
        alerts(1, 1);
        wr(8'h06, 8'h01);
    endtask
    // host masks the source: status still sets, no alert
    task automatic t_mask();
        wr(8'h08, 8'h80);
        meas(1, 0);
        alerts(1, 1);
        meas(0, 0);
        rd(8'h4F, 8'h80);
        wr(8'h08, 8'h00);
    endtask
    // pin events: their mask quiets only the bus alert; asserted-output source
    task automatic t_pin();
        wr(8'h09, 8'h04);
        overtemp_io_pin_i = 0;
        repeat (8) @(negedge core_clk);
        check("pin status", overtemp_pin_active, 1);
        alerts(1, 0);
        overtemp_io_pin_i = 1;
        overtemp_output_asserted = 1;
        repeat (8) @(negedge core_clk);
        alerts(0, 0);
        overtemp_output_asserted = 0;
        rd(8'h50, 8'h0C);
        alerts(1, 1);
        rd(8'h50, 8'h00);
        wr(8'h09, 8'h00);
    endtask
    // fan sources, stall pin and its reference mode
    task automatic t_fan();
        @(negedge core_clk);
        {fan_stall_flag, fan_alarm_speed_flag} = 2'b11;
        repeat (4) @(negedge core_clk);
        check("stall pin", fan_fault_oe, 1);
        check("stall level", fan_fault_o, 0);
        alerts(0, 0);
        rd(8'h51, 8'hC1);
        wr(8'h04, 8'h80);
        check("ref mode", ref_mode, 1);
        check("stall pin", fan_fault_oe, 0);
        {fan_stall_flag, fan_alarm_speed_flag} = 2'b00;
        wr(8'h04, 8'h00);
    endtask
    // new rate waits for the loop end
    task automatic t_rate();
        logic [7:0] n;
        n = 8'h00;
        check("averaging", averaging_en, 1);
        wr(8'h05, 8'h0A);
        check("rate", active_rate, 8'h07);
        loop_end = 1;
        @(negedge core_clk);
        loop_end = 0;
        check("rate", active_rate, 8'h0A);
        check("averaging", averaging_en, 0);
        repeat (40) @(negedge core_clk);
        repeat (16) begin
            @(negedge core_clk);
            n = n + 8'(conv_start);
        end
        check("conv ticks", n, 8'h04);
        wr(8'h05, 8'h0B);
        loop_end = 1;
        @(negedge core_clk);
        loop_end = 0;
        check("reserved rate", active_rate, 8'h0A);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) rst = 0;
        t_regs();
        t_alert();
        t_queue();
        t_mask();
        t_pin();
        t_fan();
        t_rate();
        give_verdict();
    end
endmodule
